// ---- hdl/subclock_counter.sv ----
// 15-bit sub-clock up counter with synchronous clear and per-bit carry outputs
module subclock_counter
   import subclock_timer_pkg::*;
#(
   parameter int WIDTH = CNT_W
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // control
   input  wire logic             sclk_tick,
   input  wire logic             clear,
   // state
   output logic [WIDTH-1:0]      count,
   output logic [WIDTH-1:0]      carry
);

   logic [WIDTH-1:0] count_reg;

   // counts only on sub-clock cycles, independent of machine clock choice
   always_ff @(posedge mclk) begin
      if (!rst_n || clear) begin
         count_reg <= '0;
      end else if (sclk_tick) begin
         count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // carry out of bit k: all bits up to k are ones as the count advances
   genvar k;
   generate
      for (k = 0; k < WIDTH; k++) begin : g_carry
         assign carry[k] = sclk_tick && !clear && (&count_reg[k:0]);
      end
   endgenerate

   assign count = count_reg;

endmodule

// ---- hdl/subclock_interval_timer.sv ----
// sub-clock interval timer: counter, overflow flag, watchdog taps and register slave
// Summary of operation
// - Fifteen-bit up counter advances once per sub-clock cycle while the sub-clock runs.
// - The counter always counts sub-clock cycles, whatever machine clock is selected.
// - Select codes 0 to 6 give intervals 2^9 to 2^15; code 7 is illegal.
// - Overflow flag sets when the counter bit of the selected interval carries.
// - Interrupt request is raised while overflow flag and its enable are both one.
// - With the enable at zero ovf_irq_req is not raised; irq still rises from status and mask.
// - Writing zero clears the overflow flag; writing one leaves it unchanged.
// - Writing zero to the clear bit zeroes the counter; it always reads zero.
// - Stabilization-done reads zero during a fixed 2^14 cycle wait, then one.
// - Taps at 2^10, 2^13, 2^14, 2^15 feed watchdog; 2^14 times stabilization.
// - Watchdog source select: zero routes these taps, one routes timebase taps.
// - In sub-clock mode select must be zero; at one the watchdog clock stops.
// - The overflow request is delivered as interrupt request number 26.
// - Counter clears on power-on reset, stop mode entry and hardware standby entry.
// - Overflow flag clears automatically on stop mode or hardware standby entry.
module subclock_interval_timer
   import subclock_timer_pkg::*;
(
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_n,
   // avalon-mm slave
   input  wire avl_req_t            avl_req,
   output logic [DATA_W-1:0]        avl_readdata,
   output logic                     avl_waitrequest,
   // chip mode and sub-clock
   input  wire logic                sclk_tick,
   input  wire logic                stop_entry,
   input  wire logic                standby_entry,
   input  wire logic                subclock_mode,
   // watchdog clock supply
   input  wire logic [TAP_N-1:0]    timebase_taps,
   output logic [TAP_N-1:0]         wdt_tick,
   output logic                     stab_tick,
   // interrupts
   output logic                     ovf_irq_req,
   output logic                     irq
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] carry;
   logic             cnt_clear;
   logic             wr_ctrl;
   logic             rd_status;
   logic             access;
   logic             ovf_event;
   logic             sce_event;
   logic             mode_entry;
   logic [7:0]       wbyte;

   logic             waitrequest_reg;
   logic [DATA_W-1:0] readdata_reg;
   ctrl_t            ctrl_reg;
   logic [EV_W-1:0]  status_reg;
   logic [EV_W-1:0]  status_next;
   logic [EV_W-1:0]  mask_reg;
   logic             irq_reg;
   logic             ovf_irq_reg;
   logic [TAP_N-1:0] wdt_tick_reg;
   logic             stab_tick_reg;
   logic [7:0]       ctrl_rd;

   // ---------------- bus slave ----------------
   // one wait cycle per access; the access completes at the edge where waitrequest is low
   assign access    = (avl_req.read || avl_req.write) && !waitrequest_reg;
   assign wbyte     = avl_req.writedata[7:0];
   assign wr_ctrl   = access && avl_req.write && avl_req.byteenable[0] && (avl_req.address == CTRL_OFS);
   assign rd_status = access && avl_req.read && (avl_req.address == STATUS_OFS);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         waitrequest_reg <= 1'b1;
      end else begin
         waitrequest_reg <= !((avl_req.read || avl_req.write) && waitrequest_reg);
      end
   end

   // clear bit is write-only and reads back as zero
   always_comb begin
      ctrl_rd = ctrl_reg;
      ctrl_rd[CLR_BIT] = 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         readdata_reg <= '0;
      end else if (avl_req.read && waitrequest_reg) begin
         unique case (avl_req.address)
            CTRL_OFS:   readdata_reg <= {24'h000000, ctrl_rd};
            STATUS_OFS: readdata_reg <= {30'h00000000, status_reg};
            MASK_OFS:   readdata_reg <= {30'h00000000, mask_reg};
            default:    readdata_reg <= '0;
         endcase
      end
   end

   // ---------------- counter ----------------
   assign mode_entry = stop_entry || standby_entry;
   assign cnt_clear  = mode_entry || (wr_ctrl && !wbyte[CLR_BIT]);

   subclock_counter #(
      .WIDTH     (CNT_W)
   ) u_counter (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .sclk_tick (sclk_tick),
      .clear     (cnt_clear),
      .count     (count),
      .carry     (carry)
   );

   // selected interval carry; the illegal code never overflows
   assign ovf_event = (ctrl_reg.sel != SEL_ILLEGAL) &&
                      carry[SEL_CARRY_BASE + int'(ctrl_reg.sel)];
   assign sce_event = !ctrl_reg.stabilization_done && carry[STAB_CARRY] && !mode_entry;

   // ---------------- control register ----------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg.watchdog_clock_source_select <= CTRL_RESET[WATCHDOG_CLOCK_SOURCE_SELECT_BIT];
         ctrl_reg.ie   <= CTRL_RESET[IE_BIT];
         ctrl_reg.sel  <= CTRL_RESET[SEL_LSB +: SEL_W];
         ctrl_reg.clr  <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_reg.watchdog_clock_source_select <= wbyte[WATCHDOG_CLOCK_SOURCE_SELECT_BIT];
         ctrl_reg.ie   <= wbyte[IE_BIT];
         ctrl_reg.sel  <= wbyte[SEL_LSB +: SEL_W];
         ctrl_reg.clr  <= 1'b0;
      end
   end

   // overflow flag: mode entry clears outright, a new overflow beats a software clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg.flag <= CTRL_RESET[FLAG_BIT];
      end else if (mode_entry) begin
         ctrl_reg.flag <= 1'b0;
      end else if (ovf_event) begin
         ctrl_reg.flag <= 1'b1;
      end else if (wr_ctrl && !wbyte[FLAG_BIT]) begin
         ctrl_reg.flag <= 1'b0;
      end
   end

   // stabilization wait restarts with the counter on reset and mode entry
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_reg.stabilization_done <= CTRL_RESET[SCE_BIT];
      end else if (mode_entry) begin
         ctrl_reg.stabilization_done <= 1'b0;
      end else if (sce_event) begin
         ctrl_reg.stabilization_done <= 1'b1;
      end
   end

   // ---------------- watchdog clock supply ----------------
   genvar t;
   generate
      for (t = 0; t < TAP_N; t++) begin : g_tap
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               wdt_tick_reg[t] <= 1'b0;
            end else if (ctrl_reg.watchdog_clock_source_select) begin
               wdt_tick_reg[t] <= timebase_taps[t] && !subclock_mode;
            end else begin
               wdt_tick_reg[t] <= carry[TAP_CARRY[t]];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stab_tick_reg <= 1'b0;
      end else begin
         stab_tick_reg <= carry[STAB_CARRY];
      end
   end

   // ---------------- interrupts ----------------
   always_comb begin
      status_next = status_reg;
      // a finishing read clears only what it reported, so an event caught at the load edge survives
      if (rd_status) begin
         status_next = status_reg & ~readdata_reg[EV_W-1:0];
      end
      if (ovf_event) begin
         status_next[EV_OVF_BIT] = 1'b1;
      end
      if (sce_event) begin
         status_next[EV_SCE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_reg <= '0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mask_reg <= MASK_RESET;
      end else if (access && avl_req.write && avl_req.byteenable[0] && (avl_req.address == MASK_OFS)) begin
         mask_reg <= wbyte[EV_W-1:0];
      end
   end

   // request line for interrupt number IRQ_NUMBER
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovf_irq_reg <= 1'b0;
      end else begin
         ovf_irq_reg <= ctrl_reg.flag && ctrl_reg.ie;
      end
   end

   assign avl_readdata    = readdata_reg;
   assign avl_waitrequest = waitrequest_reg;
   assign wdt_tick        = wdt_tick_reg;
   assign stab_tick       = stab_tick_reg;
   assign ovf_irq_req     = ovf_irq_reg;
   assign irq             = irq_reg;

   // ---------------- checks ----------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_count_advance: assert property (
      sclk_tick && !cnt_clear |=> count == $past(count) + 15'h0001)
      else $error("counter did not advance on a sub-clock tick");

   chk_illegal_sel: assert property (
      ctrl_reg.sel == SEL_ILLEGAL && !wr_ctrl |=> !$rose(ctrl_reg.flag))
      else $error("overflow flag set with illegal interval select");

   chk_flag_set: assert property (
      ovf_event && !mode_entry |=> ctrl_reg.flag ##1 status_reg[EV_OVF_BIT] || $past(rd_status))
      else $error("overflow did not set the flag");

   chk_irq_request: assert property (
      ctrl_reg.flag && ctrl_reg.ie |=> ovf_irq_req)
      else $error("interrupt request missing with flag and enable set");

   chk_irq_disabled: assert property (
      !ctrl_reg.ie |=> !ovf_irq_req)
      else $error("interrupt request raised while disabled");

   chk_flag_write0: assert property (
      wr_ctrl && !wbyte[FLAG_BIT] && !ovf_event |=> !ctrl_reg.flag)
      else $error("writing zero did not clear the flag");

   chk_clear_write: assert property (
      wr_ctrl && !wbyte[CLR_BIT] |=> count == 15'h0000 ##1 avl_readdata[CLR_BIT] == 1'b0)
      else $error("clear bit write did not zero the counter");

   chk_sce_rise: assert property (
      $rose(ctrl_reg.stabilization_done) |-> $past(carry[STAB_CARRY]) && $past(count) == 15'h3FFF)
      else $error("stabilization done rose outside the 2^14 point");

   chk_wdt_stop: assert property (
      subclock_mode && ctrl_reg.watchdog_clock_source_select |=> wdt_tick == '0)
      else $error("watchdog clock ran in sub-clock mode with timebase selected");

   chk_mode_clear: assert property (
      mode_entry |=> count == 15'h0000 && !ctrl_reg.flag && !ctrl_reg.stabilization_done)
      else $error("mode entry did not clear counter, flag and stabilization");

   chk_flag_hold: assert property (
      ctrl_reg.flag && !mode_entry && !(wr_ctrl && !wbyte[FLAG_BIT]) |=> ctrl_reg.flag)
      else $error("overflow flag dropped without a clear");

   cov_overflow: cover property (ovf_event ##1 ctrl_reg.flag ##1 ovf_irq_req);
   cov_stab_done: cover property ($rose(ctrl_reg.stabilization_done));
   cov_status_read: cover property (rd_status && status_reg != '0 ##2 !irq);
   cov_sw_clear: cover property (wr_ctrl && !wbyte[FLAG_BIT] && ctrl_reg.flag);

endmodule

// ---- hdl/subclock_timer_pkg.sv ----
// constants, register layout and bus carrier types for the sub-clock interval timer
package subclock_timer_pkg;

   localparam int CNT_W        = 15;
   localparam int SEL_W        = 3;
   localparam int TAP_N        = 4;
   localparam int ADDR_W       = 4;
   localparam int DATA_W       = 32;
   localparam int IRQ_NUMBER   = 26;

   // byte addresses of the registers
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h8;

   // control register field positions
   localparam int WATCHDOG_CLOCK_SOURCE_SELECT_BIT  = 7;
   localparam int SCE_BIT   = 6;
   localparam int IE_BIT    = 5;
   localparam int FLAG_BIT  = 4;
   localparam int CLR_BIT   = 3;
   localparam int SEL_LSB   = 0;

   localparam logic [7:0] CTRL_RESET = 8'h80;
   localparam logic [SEL_W-1:0] SEL_ILLEGAL = 3'h7;

   // status / mask layout
   localparam int EV_W        = 2;
   localparam int EV_OVF_BIT  = 0;
   localparam int EV_SCE_BIT  = 1;
   localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

   // carry index: interval 2^n ends with the carry out of bit n-1
   localparam int SEL_CARRY_BASE = 8;
   localparam int STAB_CARRY     = 13;
   localparam int TAP_CARRY [TAP_N] = '{9, 12, 13, 14};

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [3:0]        byteenable;
   } avl_req_t;

   typedef struct packed {
      logic              watchdog_clock_source_select;
      logic              stabilization_done;
      logic              ie;
      logic              flag;
      logic              clr;
      logic [SEL_W-1:0]  sel;
   } ctrl_t;

endpackage

// ---- verif/subclock_partner.sv ----
// partner model: watchdog clock counter and timebase tap source
module subclock_partner
   import subclock_timer_pkg::*;
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // watchdog clock supply
   input  wire logic [TAP_N-1:0] wdt_tick,
   input  wire logic             wdt_clear,
   output logic [TAP_N-1:0]      timebase_taps,
   output logic [15:0]           tick_cnt
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [2:0] div_reg;

   // timebase source: one pulse on every tap each 8 cycles, low otherwise
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_reg <= 3'h0;
         timebase_taps <= '0;
      end else begin
         div_reg <= div_reg + 3'h1;
         timebase_taps <= {TAP_N{div_reg == 3'h7}};
      end
   end

   // watchdog advances once per pulse on wdt_tick[0]; no pulse means a stopped watchdog
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_cnt <= 16'h0000;
      end else if (wdt_clear) begin
         tick_cnt <= 16'h0000;
      end else if (wdt_tick[0]) begin
         tick_cnt <= tick_cnt + 16'h0001;
      end
   end
endmodule

// ---- verif/test_subclock_interval_timer.sv ----
// self-checking testbench for the sub-clock interval timer
module test_subclock_interval_timer;
   timeunit 1ns;
   timeprecision 1ns;
   import subclock_timer_pkg::*;

   logic              mclk, rst_n, sclk_tick, stop_entry, standby_entry, subclock_mode, wdt_clear;
   avl_req_t          avl_req;
   logic [DATA_W-1:0] avl_readdata;
   logic              avl_waitrequest, stab_tick, ovf_irq_req, irq, ie;
   logic [TAP_N-1:0]  timebase_taps, wdt_tick;
   logic [15:0]       tick_cnt, c0;
   logic [2:0]        sel;
   logic [31:0]       rd;
   int                fails, checks, stab_cnt;

   subclock_interval_timer i_dut (.mclk(mclk), .rst_n(rst_n), .avl_req(avl_req), .avl_readdata(avl_readdata),
      .avl_waitrequest(avl_waitrequest), .sclk_tick(sclk_tick), .stop_entry(stop_entry),
      .standby_entry(standby_entry), .subclock_mode(subclock_mode), .timebase_taps(timebase_taps),
      .wdt_tick(wdt_tick), .stab_tick(stab_tick), .ovf_irq_req(ovf_irq_req), .irq(irq));

   subclock_partner i_wd (.mclk(mclk), .rst_n(rst_n), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
      .timebase_taps(timebase_taps), .tick_cnt(tick_cnt));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // stabilization tap pulses seen since reset
   always @(posedge mclk) begin
      if (!rst_n) begin
         stab_cnt <= 0;
      end else if (stab_tick === 1'b1) begin
         stab_cnt <= stab_cnt + 1;
      end
   end

   task automatic final_report;
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one bus access: request held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avl_req.read <= ~wr;
      avl_req.write <= wr;
      avl_req.address <= a;
      avl_req.writedata <= {24'h000000, d};
      avl_req.byteenable <= 4'hF;
      do begin
         @(posedge mclk);
         n++;
      end while (avl_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
      rd = avl_readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
      bus(1'b0, a, 8'h00);
      chk(nm, {24'h000000, e}, rd);
   endtask

   // control byte: watchdog_clock_source_select, sce, ie, flag, clear bit, interval select
   function automatic logic [7:0] ctl(logic w, logic s, logic i, logic f, logic c, logic [2:0] v);
      return {w, s, i, f, c, v};
   endfunction

   initial begin
      #4750000;
      fails++;
      final_report();
   end

   initial begin
      rst_n = 1'b0;
      sclk_tick = 1'b0;
      stop_entry = 1'b0;
      standby_entry = 1'b0;
      subclock_mode = 1'b0;
      wdt_clear = 1'b0;
      avl_req = '0;
      fails = 0;
      checks = 0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      sclk_tick <= 1'b1;
      rd_chk(CTRL_OFS, 8'h80, "ctrl reset");
      rd_chk(MASK_OFS, 8'h00, "mask reset");
      rd_chk(4'hC, 8'h00, "unmapped read");
      repeat (16400) @(posedge mclk);
      chk("stab ticks", 32'd1, 32'(stab_cnt));
      rd_chk(CTRL_OFS, 8'hD0, "ctrl stable");
      rd_chk(STATUS_OFS, 8'h03, "status events");
      bus(1'b1, MASK_OFS, 8'h01);
      for (int s = 0; s < 7; s++) begin
         sel = 3'(s);
         ie = sel[0];
         bus(1'b1, CTRL_OFS, ctl(1'h0, 1'h0, ie, 1'h0, 1'h0, sel));
         bus(1'b0, STATUS_OFS, 8'h00);
         repeat ((1 << (9 + s)) - 24) @(posedge mclk);
         rd_chk(CTRL_OFS, ctl(1'h0, 1'h1, ie, 1'h0, 1'h0, sel), "ctrl before");
         chk("irq before", 32'h0, {31'h0, irq});
         repeat (40) @(posedge mclk);
         rd_chk(CTRL_OFS, ctl(1'h0, 1'h1, ie, 1'h1, 1'h0, sel), "ctrl after");
         chk("ovf request", {31'h0, ie}, {31'h0, ovf_irq_req});
         chk("irq", 32'h1, {31'h0, irq});
         rd_chk(STATUS_OFS, 8'h01, "status");
         rd_chk(MASK_OFS, 8'h01, "mask");
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
      bus(1'b1, CTRL_OFS, 8'h1E);
      rd_chk(CTRL_OFS, 8'h56, "flag kept");
      bus(1'b1, CTRL_OFS, 8'h0E);
      rd_chk(CTRL_OFS, 8'h46, "flag cleared");
      bus(1'b1, CTRL_OFS, 8'h00);
      repeat (300) @(posedge mclk);
      bus(1'b1, CTRL_OFS, 8'h00);
      repeat (300) @(posedge mclk);
      rd_chk(CTRL_OFS, 8'h40, "counter cleared");
      repeat (240) @(posedge mclk);
      rd_chk(CTRL_OFS, 8'h50, "flag after clear");
      for (int k = 0; k < 3; k++) begin
         if (k == 1) begin
            wdt_clear <= 1'b1;
            @(posedge mclk);
            wdt_clear <= 1'b0;
            bus(1'b1, CTRL_OFS, 8'h8F);
            wdt_clear <= 1'b1;
            @(posedge mclk);
            wdt_clear <= 1'b0;
         end
         if (k == 2) subclock_mode <= 1'b1;
         repeat (8) @(posedge mclk);
         c0 = tick_cnt;
         repeat (2048) @(posedge mclk);
         chk("watchdog ticks", (k == 0) ? 32'd2 : (k == 1) ? 32'd256 : 32'd0, 32'(tick_cnt - c0));
      end
      subclock_mode <= 1'b0;
      rd_chk(CTRL_OFS, 8'hC7, "illegal select");
      bus(1'b1, CTRL_OFS, 8'h98);
      for (int m = 0; m < 2; m++) begin
         repeat (600) @(posedge mclk);
         rd_chk(CTRL_OFS, (m == 0) ? 8'hD0 : 8'h90, "flag before mode");
         @(posedge mclk);
         stop_entry <= (m == 0);
         standby_entry <= (m == 1);
         @(posedge mclk);
         stop_entry <= 1'b0;
         standby_entry <= 1'b0;
         rd_chk(CTRL_OFS, 8'h80, "mode entry");
         repeat (400) @(posedge mclk);
         rd_chk(CTRL_OFS, 8'h80, "counter restarted");
      end
      final_report();
   end
endmodule
